// ---- inc/sdc_cfg.svh ----
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define SDC_ADDR_W 16
`define SDC_DATA_W 4
`define SDC_A_KEYSWAP 16'hff06
`define SDC_A_DKEY 16'hff78
`define SDC_A_CTRL 16'hff79
`define SDC_A_CAP_MS 16'hff7a
`define SDC_A_CAP_HS 16'hff7b
`define SDC_A_CAP_TS 16'hff7c
`define SDC_A_IRQ_EN 16'hffe6
`define SDC_A_IRQ_FLAG 16'hfff6

// ****************************************************************
// Field positions
// ****************************************************************
`define SDC_B_KEYSWAP 2
`define SDC_B_DKEY_EN 3
`define SDC_B_CLEAR 0
`define SDC_B_RUN 1
`define SDC_B_RENEW 2
`define SDC_B_CARRY 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define SDC_RST_NIB 4'h0
`define SDC_RST_SEL 3'h0
`define SDC_RST_CAP 12'h000
`define SDC_MASK_KEYS 6
`define SDC_NO_MASK 6'h00

`endif

// ---- inc/sdc_pkg.sv ----
package sdc_pkg;

  // Interrupt sources in register bit order, run key at bit 3.
  typedef struct packed {
    logic run;
    logic lap;
    logic hz1;
    logic hz10;
  } sdc_irq_t;

  // Capture buffer: tracking the count, held by a read, held by lap.
  typedef enum logic [1:0] {
    SDC_TRACK = 2'b00,
    SDC_HOLD = 2'b01,
    SDC_LAP = 2'b11
  } sdc_cap_t;

  // Register port request.
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } sdc_bus_t;

endpackage : sdc_pkg

// ---- hdl/sdc_ctrl.sv ----
`timescale 1ns/10ps
`include "sdc_cfg.svh"
module sdc_ctrl
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sdc_bus_t bus,
  output logic [3:0] rdata,
  input wire logic key_port_a,
  input wire logic key_port_b,
  input wire logic [5:0] mask_keys,
  input wire logic div32_fall,
  input wire logic tick_1hz,
  input wire logic tick_10hz,
  input wire logic [11:0] count_bcd,
  output logic stopwatch_running,
  output logic count_clear,
  output sdc_irq_t irq_req
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pin_prev <= 8'h00;
    end else if (ce) begin
      pin_meta <= {mask_keys, key_port_b, key_port_a};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Decodes the concurrent key mask code to a set of mask keys.
  function automatic logic [5:0] key_mask(input logic [2:0] sel);
    logic [5:0] m;
    m = `SDC_NO_MASK;
    case (sel)
      3'h1: m = 6'h01;
      3'h2: m = 6'h03;
      3'h3: m = 6'h07;
      3'h4: m = 6'h04;
      3'h5: m = 6'h0c;
      3'h6: m = 6'h1c;
      3'h7: m = 6'h3c;
      default: m = `SDC_NO_MASK;
    endcase
    return m;
  endfunction : key_mask

  // ****************************************************************
  // State
  // ****************************************************************
  logic key_swap_select;
  logic [2:0] concurrent_key_mask_select;
  logic direct_key_enable;
  logic dkey_active;
  logic stopwatch_run_bit;
  logic lap_carry_request_flag;
  logic capture_renewed_flag;
  logic renew_pending;
  sdc_cap_t cap_state;
  logic [11:0] cap_buf;
  sdc_irq_t irq_enable;
  sdc_irq_t irq_flag;
  logic next_key_swap_select;
  logic [2:0] next_concurrent_key_mask_select;
  logic next_direct_key_enable;
  logic next_dkey_active;
  logic next_stopwatch_run_bit;
  logic next_lap_carry_request_flag;
  logic next_capture_renewed_flag;
  logic next_renew_pending;
  sdc_cap_t next_cap_state;
  logic [11:0] next_cap_buf;
  sdc_irq_t next_irq_enable;
  sdc_irq_t next_irq_flag;
  logic next_count_clear;
  logic [3:0] next_rdata;

  logic run_pin;
  logic lap_pin;
  logic run_press;
  logic lap_press;
  logic concurrent;
  logic run_ok;
  logic lap_ok;
  logic wr_swap;
  logic wr_dkey;
  logic wr_ctrl;
  logic wr_en;
  logic wr_flag;
  logic rd_ms;
  logic rd_ts;

  // ****************************************************************
  // Key decode
  // ****************************************************************
  always_comb begin
    run_pin = key_swap_select ? pin_sync[1] : pin_sync[0];
    lap_pin = key_swap_select ? pin_sync[0] : pin_sync[1];
    run_press = run_pin &
      !(key_swap_select ? pin_prev[1] : pin_prev[0]);
    lap_press = lap_pin &
      !(key_swap_select ? pin_prev[0] : pin_prev[1]);
    concurrent = |(pin_sync[7:2] &
      key_mask(concurrent_key_mask_select));
    run_ok = dkey_active & run_press & !concurrent;
    lap_ok = dkey_active & lap_press & !concurrent;
    wr_swap = bus.wr & (bus.addr == `SDC_A_KEYSWAP);
    wr_dkey = bus.wr & (bus.addr == `SDC_A_DKEY);
    wr_ctrl = bus.wr & (bus.addr == `SDC_A_CTRL);
    wr_en = bus.wr & (bus.addr == `SDC_A_IRQ_EN);
    wr_flag = bus.wr & (bus.addr == `SDC_A_IRQ_FLAG);
    rd_ms = bus.rd & (bus.addr == `SDC_A_CAP_MS);
    rd_ts = bus.rd & (bus.addr == `SDC_A_CAP_TS);
  end

  // ****************************************************************
  // Control and flags
  // ****************************************************************
  always_comb begin
    next_key_swap_select = key_swap_select;
    next_concurrent_key_mask_select = concurrent_key_mask_select;
    next_direct_key_enable = direct_key_enable;
    next_dkey_active = dkey_active;
    next_stopwatch_run_bit = stopwatch_run_bit;
    next_irq_enable = irq_enable;
    next_irq_flag = irq_flag;
    next_count_clear = 1'b0;
    if (wr_swap) begin
      next_key_swap_select = bus.wdata[`SDC_B_KEYSWAP];
    end
    if (wr_dkey) begin
      next_direct_key_enable = bus.wdata[`SDC_B_DKEY_EN];
      next_concurrent_key_mask_select = bus.wdata[2:0];
    end
    if (div32_fall) begin
      next_dkey_active = direct_key_enable;
    end
    if (wr_ctrl) begin
      next_count_clear = bus.wdata[`SDC_B_CLEAR];
    end
    if (wr_ctrl && !dkey_active) begin
      next_stopwatch_run_bit = bus.wdata[`SDC_B_RUN];
    end
    if (run_ok) begin
      next_stopwatch_run_bit = !stopwatch_run_bit;
    end
    if (wr_en) begin
      next_irq_enable = sdc_irq_t'(bus.wdata);
    end
    if (wr_flag) begin
      next_irq_flag = sdc_irq_t'(irq_flag & ~bus.wdata);
    end
    next_irq_flag.run = next_irq_flag.run | run_ok;
    next_irq_flag.lap = next_irq_flag.lap | lap_ok;
    next_irq_flag.hz1 = next_irq_flag.hz1 | tick_1hz;
    next_irq_flag.hz10 = next_irq_flag.hz10 | tick_10hz;
  end

  // ****************************************************************
  // Capture buffer
  // ****************************************************************
  always_comb begin
    next_cap_state = cap_state;
    next_cap_buf = cap_buf;
    next_lap_carry_request_flag = lap_carry_request_flag;
    next_capture_renewed_flag = capture_renewed_flag;
    next_renew_pending = renew_pending;
    if (cap_state == SDC_TRACK) begin
      next_cap_buf = count_bcd;
    end
    if (rd_ms && cap_state == SDC_TRACK) begin
      next_cap_state = SDC_HOLD;
      next_lap_carry_request_flag = irq_flag.hz1;
    end else if (rd_ms && cap_state == SDC_LAP) begin
      next_cap_state = SDC_HOLD;
    end
    if (rd_ts) begin
      next_capture_renewed_flag = renew_pending;
      next_renew_pending = 1'b0;
      if (!renew_pending) begin
        next_cap_state = SDC_TRACK;
      end else begin
        next_cap_state = SDC_HOLD;
      end
    end
    if (lap_ok) begin
      next_cap_buf = count_bcd;
      next_cap_state = SDC_LAP;
      next_lap_carry_request_flag = irq_flag.hz1;
      if (cap_state == SDC_LAP) begin
        next_renew_pending = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    next_rdata = `SDC_RST_NIB;
    case (bus.addr)
      `SDC_A_KEYSWAP: next_rdata[`SDC_B_KEYSWAP] = key_swap_select;
      `SDC_A_DKEY: next_rdata = {direct_key_enable,
        concurrent_key_mask_select};
      `SDC_A_CTRL: next_rdata = {lap_carry_request_flag,
        capture_renewed_flag, stopwatch_run_bit, 1'b0};
      `SDC_A_CAP_MS: next_rdata = next_cap_buf[3:0];
      `SDC_A_CAP_HS: next_rdata = cap_buf[7:4];
      `SDC_A_CAP_TS: next_rdata = cap_buf[11:8];
      `SDC_A_IRQ_EN: next_rdata = irq_enable;
      `SDC_A_IRQ_FLAG: next_rdata = irq_flag;
      default: next_rdata = `SDC_RST_NIB;
    endcase
    if (!bus.rd) begin
      next_rdata = `SDC_RST_NIB;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_swap_select <= 1'b0;
      concurrent_key_mask_select <= `SDC_RST_SEL;
      direct_key_enable <= 1'b0;
      dkey_active <= 1'b0;
      stopwatch_run_bit <= 1'b0;
      lap_carry_request_flag <= 1'b0;
      capture_renewed_flag <= 1'b0;
      renew_pending <= 1'b0;
      cap_state <= SDC_TRACK;
      cap_buf <= `SDC_RST_CAP;
      irq_enable <= sdc_irq_t'(`SDC_RST_NIB);
      irq_flag <= sdc_irq_t'(`SDC_RST_NIB);
      count_clear <= 1'b0;
      rdata <= `SDC_RST_NIB;
      irq_req <= sdc_irq_t'(`SDC_RST_NIB);
    end else if (ce) begin
      key_swap_select <= next_key_swap_select;
      concurrent_key_mask_select <= next_concurrent_key_mask_select;
      direct_key_enable <= next_direct_key_enable;
      dkey_active <= next_dkey_active;
      stopwatch_run_bit <= next_stopwatch_run_bit;
      lap_carry_request_flag <= next_lap_carry_request_flag;
      capture_renewed_flag <= next_capture_renewed_flag;
      renew_pending <= next_renew_pending;
      cap_state <= next_cap_state;
      cap_buf <= next_cap_buf;
      irq_enable <= next_irq_enable;
      irq_flag <= next_irq_flag;
      count_clear <= next_count_clear;
      rdata <= next_rdata;
      irq_req <= sdc_irq_t'(next_irq_flag & next_irq_enable);
    end
  end

  assign stopwatch_running = stopwatch_run_bit;

endmodule : sdc_ctrl

// ---- testbench/sdc_ctrl_checker.sv ----
`timescale 1ns/10ps
`include "sdc_cfg.svh"
module sdc_ctrl_checker
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire sdc_bus_t bus,
  input wire logic [3:0] rdata,
  input wire logic key_port_a,
  input wire logic key_port_b,
  input wire logic [5:0] mask_keys,
  input wire logic div32_fall,
  input wire logic tick_1hz,
  input wire logic tick_10hz,
  input wire logic [11:0] count_bcd,
  input wire logic stopwatch_running,
  input wire logic count_clear,
  input wire sdc_irq_t irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic wc, rdc, ew, fw;
  assign wc = ce && bus.wr && bus.addr == `SDC_A_CTRL;
  assign rdc = ce && bus.rd && bus.addr == `SDC_A_CTRL;
  assign ew = bus.wr && bus.addr == `SDC_A_IRQ_EN;
  assign fw = ce && bus.wr && bus.addr == `SDC_A_IRQ_FLAG;
  // ****
  // Port relations
  // ****
  a_clear_pulse:
    assert property (wc |=> count_clear == $past(bus.wdata[0]))
    else $error("clear pulse does not follow the clear bit");
  a_clear_cause:
    assert property (count_clear |-> $past(wc) && $past(bus.wdata[0]))
    else $error("clear pulse without a clear write");
  a_clear_reads0:
    assert property (rdc |=> !rdata[0])
    else $error("clear bit read back as one");
  a_run_readback:
    assert property (rdc |=> rdata[1] == $past(stopwatch_running))
    else $error("run bit read differs from running state");
  a_req_held:
    assert property (ce && !bus.wr && !$past(bus.wr) |=>
      ($past(irq_req) & ~irq_req) == 4'h0)
    else $error("request dropped without a write");
  a_hz1_w1c:
    assert property (fw && bus.wdata[1] && !tick_1hz ##1 !tick_1hz |=>
      !irq_req.hz1)
    else $error("1 Hz request not cleared by write one");
  a_hz1_cause:
    assert property (ce && !irq_req.hz1 && !tick_1hz && !$past(tick_1hz)
      && !ew && !$past(ew) |=> !irq_req.hz1)
    else $error("1 Hz request rose without tick or enable");
  a_hz10_cause:
    assert property ($rose(irq_req.hz10) && $past(ce) && $past(ce, 2) |->
      $past(tick_10hz) || $past(tick_10hz, 2) || $past(ew) || $past(ew, 2))
    else $error("10 Hz request rose without tick or enable");
  c_clear: cover property (count_clear);
  c_run: cover property ($rose(stopwatch_running));
  c_hz10: cover property (irq_req.hz10);
endmodule : sdc_ctrl_checker
bind sdc_ctrl sdc_ctrl_checker sdc_ctrl_checker_inst (.clk(clk),
  .rst_n(rst_n), .ce(ce), .bus(bus), .rdata(rdata),
  .key_port_a(key_port_a), .key_port_b(key_port_b),
  .mask_keys(mask_keys), .div32_fall(div32_fall), .tick_1hz(tick_1hz),
  .tick_10hz(tick_10hz), .count_bcd(count_bcd),
  .stopwatch_running(stopwatch_running), .count_clear(count_clear),
  .irq_req(irq_req));

// ---- testbench/sdc_key_model.sv ----
`timescale 1ns/10ps
// ****
// Key pad model, pins high while pressed
// ****
module sdc_key_model (
  input wire logic clk,
  output logic key_port_a,
  output logic key_port_b,
  output logic [5:0] mask_keys
);
  initial begin
    key_port_a = 1'b0;
    key_port_b = 1'b0;
    mask_keys = 6'h00;
  end
  task hold(input logic [5:0] m);
    @(posedge clk);
    mask_keys <= m;
  endtask : hold
  // A press lasts six cycles so the synchroniser cannot miss it.
  task tap(input int k);
    @(posedge clk);
    if (k == 0) begin
      key_port_a <= 1'b1;
    end else begin
      key_port_b <= 1'b1;
    end
    repeat (6) @(posedge clk);
    key_port_a <= 1'b0;
    key_port_b <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : tap
endmodule : sdc_key_model

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`include "sdc_cfg.svh"
module tb
  import sdc_pkg::*;
;
  logic clk, rst_n, ce, div32_fall, tick_1hz, tick_10hz;
  logic key_port_a, key_port_b, stopwatch_running, count_clear;
  logic [5:0] mask_keys;
  logic [3:0] rdata, b;
  logic [11:0] count_bcd, e;
  logic [11:0] laps[$];
  logic [15:0] adrs[6] = '{16'hff06, 16'hff78, 16'hff79, 16'hffe6,
    16'hfff6, 16'h1234};
  sdc_bus_t bus;
  sdc_irq_t irq_req;
  int n_fail = 0;
  int num_checks = 0;
  int m_run;
  sdc_ctrl sdc_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rdata(rdata), .key_port_a(key_port_a), .key_port_b(key_port_b),
    .mask_keys(mask_keys), .div32_fall(div32_fall), .tick_1hz(tick_1hz),
    .tick_10hz(tick_10hz), .count_bcd(count_bcd),
    .stopwatch_running(stopwatch_running), .count_clear(count_clear),
    .irq_req(irq_req));
  sdc_key_model sdc_key_model_inst (.clk(clk), .key_port_a(key_port_a),
    .key_port_b(key_port_b), .mask_keys(mask_keys));
  // ****
  // Bench tasks
  // ****
  task close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rc(input logic [15:0] a, input logic [3:0] x);
    @(posedge clk);
    bus <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(12'(rdata), 12'(x));
  endtask : rc
  task pulse(input int s);
    @(posedge clk);
    div32_fall <= (s == 0);
    tick_1hz <= (s == 1);
    tick_10hz <= (s == 2);
    @(posedge clk);
    {div32_fall, tick_1hz, tick_10hz} <= 3'h0;
  endtask : pulse
  function automatic logic [11:0] bcd();
    return {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
  endfunction : bcd
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    void'($urandom(44));
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    count_bcd = 12'h000;
    {div32_fall, tick_1hz, tick_10hz} = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (adrs[i]) rc(adrs[i], 4'h0);
    repeat (2) begin
      b = 4'($urandom % 16);
      wr(`SDC_A_IRQ_EN, b);
      rc(`SDC_A_IRQ_EN, b);
    end
    wr(`SDC_A_IRQ_EN, 4'h0);
    wr(`SDC_A_KEYSWAP, 4'hf);
    rc(`SDC_A_KEYSWAP, 4'h4);
    wr(`SDC_A_CTRL, 4'h2);
    rc(`SDC_A_CTRL, 4'h2);
    wr(`SDC_A_CTRL, 4'h3);
    #1;
    chk(12'(count_clear), 12'h1);
    rc(`SDC_A_CTRL, 4'h2);
    for (int s = 1; s < 3; s++) begin
      b = 4'(3 - s);
      pulse(s);
      rc(`SDC_A_IRQ_FLAG, b);
      chk(12'(irq_req), 12'h0);
      wr(`SDC_A_IRQ_EN, b);
      @(posedge clk);
      #1;
      chk(12'(irq_req), 12'(b));
      wr(`SDC_A_IRQ_FLAG, 4'h0);
      rc(`SDC_A_IRQ_FLAG, b);
      wr(`SDC_A_IRQ_FLAG, b);
      rc(`SDC_A_IRQ_FLAG, 4'h0);
      wr(`SDC_A_IRQ_EN, 4'h0);
    end
    wr(`SDC_A_DKEY, 4'h8);
    wr(`SDC_A_CTRL, 4'h0);
    rc(`SDC_A_CTRL, 4'h0);
    pulse(0);
    wr(`SDC_A_CTRL, 4'h2);
    rc(`SDC_A_CTRL, 4'h0);
    m_run = 0;
    for (int k = 0; k < 2; k++) begin
      wr(`SDC_A_KEYSWAP, 4'(4 * k));
      sdc_key_model_inst.tap(k);
      m_run = 1 - m_run;
      rc(`SDC_A_CTRL, 4'(2 * m_run));
      chk(12'(stopwatch_running), 12'(m_run));
      rc(`SDC_A_IRQ_FLAG, 4'h8);
      wr(`SDC_A_IRQ_FLAG, 4'h8);
    end
    for (int c = 1; c < 8; c++) begin
      wr(`SDC_A_DKEY, 4'(8 + c));
      rc(`SDC_A_DKEY, 4'(8 + c));
      sdc_key_model_inst.hold(6'(1 << (c < 4 ? c - 1 : c - 2)));
      sdc_key_model_inst.tap(1);
      sdc_key_model_inst.hold(6'h00);
      rc(`SDC_A_CTRL, 4'(2 * m_run));
      rc(`SDC_A_IRQ_FLAG, 4'h0);
    end
    // A key outside the selected mask must not block a press.
    sdc_key_model_inst.hold(6'h01);
    sdc_key_model_inst.tap(1);
    sdc_key_model_inst.hold(6'h00);
    m_run = 1 - m_run;
    rc(`SDC_A_CTRL, 4'(2 * m_run));
    rc(`SDC_A_IRQ_FLAG, 4'h8);
    wr(`SDC_A_IRQ_FLAG, 4'h8);
    wr(`SDC_A_DKEY, 4'h8);
    pulse(1);
    repeat (2) begin
      laps.push_back(bcd());
      count_bcd <= laps[$];
      sdc_key_model_inst.tap(0);
    end
    e = laps[$];
    for (int d = 0; d < 3; d++) begin
      rc(`SDC_A_CAP_MS + 16'(d), e[4 * d +: 4]);
    end
    rc(`SDC_A_CTRL, 4'(12 + 2 * m_run));
    rc(`SDC_A_IRQ_FLAG, 4'h6);
    wr(`SDC_A_CTRL, 4'h1);
    count_bcd <= 12'h000;
    wr(`SDC_A_IRQ_FLAG, 4'hf);
    rc(`SDC_A_CAP_MS, e[3:0]);
    rc(`SDC_A_CAP_HS, e[7:4]);
    rc(`SDC_A_CAP_TS, e[11:8]);
    rc(`SDC_A_CAP_MS, 4'h0);
    rc(`SDC_A_CTRL, 4'(2 * m_run));
    close_out();
  end
endmodule : tb
